// ===== verilog/mmc_pkg.sv
// package for the memory map decoder and configuration loader
// assumes a single 40 MHz clock domain and an axi4-lite register master
//
// Overview of operation
// - large top program area goes internal or external
// - high internal ram aliases low code ram
// - register ram, can and sfr windows decoded
// - cpu sfrs then lower register file
// - code ram only by indirect or indexed
// - low segment program memory needs mirror and pin
// - fetches below 0400H always go external
// - small variant internal program and external ranges
// - small variant upper register file decode
// - first byte: powerdown allow, write strobe style
// - first byte bit 3 picks address strobe
// - two protect bits give four protection levels
// - second byte bit 0 fetches third byte
// - watchdog forced on when bit 3 zero
// - timing bits choose wait or no-wait mode
// - three ready bits cap wait states
// - two width bits choose bus width
// - third byte bit 1 selects address width
// - third byte bit 2 mirrors into segment zero
// - high strobe on odd writes, or on any odd 16-bit access when first byte bit 2 set
package mmc_pkg;
  // ----------------------------------------------------------------
  // configuration byte locations
  // ----------------------------------------------------------------
  localparam logic [23:0] CFG_A_ADDR = 24'h002018;
  localparam logic [23:0] CFG_B_ADDR = 24'h00201A;
  localparam logic [23:0] CFG_C_ADDR = 24'h00201C;
  localparam logic [7:0] CFG_ERASED = 8'hFF;
  // register indices as the byte locations give them; each register takes a
  // whole word, so the bus offset is four times the low bits of the index
  localparam logic [15:0] IDX_CFG_A = 16'h2018;
  localparam logic [15:0] IDX_CFG_B = 16'h201A;
  localparam logic [15:0] IDX_CFG_C = 16'h201C;
  localparam logic [11:0] REG_CFG_A = {IDX_CFG_A[9:0], 2'b00};
  localparam logic [11:0] REG_CFG_B = {IDX_CFG_B[9:0], 2'b00};
  localparam logic [11:0] REG_CFG_C = {IDX_CFG_C[9:0], 2'b00};
  localparam logic [11:0] REG_STATUS = 12'h020;
  localparam logic [11:0] REG_PROBE = 12'h024;
  localparam logic [11:0] REG_RESULT = 12'h028;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // field positions
  localparam int A_POWERDOWN_ALLOW = 0;
  localparam int A_BUS_SIZE_B0 = 1;
  localparam int A_WR = 2;
  localparam int A_ALE = 3;
  localparam int A_READY_LIMIT_B0 = 4;
  localparam int A_READY_LIMIT_B1 = 5;
  localparam int A_PROTECT_SEL_LO = 6;
  localparam int A_PROTECT_SEL_HI = 7;
  localparam int B_FETCH_C = 0;
  localparam int B_READY_LIMIT_B2 = 1;
  localparam int B_BUS_SIZE_B1 = 2;
  localparam int B_WATCHDOG_FORCE_BIT = 3;
  localparam int B_MS0 = 6;
  localparam int B_MS1 = 7;
  localparam int C_WIDE = 1;
  localparam int C_MIRROR = 2;
  // ----------------------------------------------------------------
  // targets of the decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MMC_TGT_CPU_SFR = 4'h0,
    MMC_TGT_LOW_REG = 4'h1,
    MMC_TGT_UP_REG = 4'h2,
    MMC_TGT_CODE_RAM = 4'h3,
    MMC_TGT_REG_RAM = 4'h4,
    MMC_TGT_CAN = 4'h5,
    MMC_TGT_PERIPH_SFR = 4'h6,
    MMC_TGT_MM_SFR = 4'h7,
    MMC_TGT_PROG = 4'h8,
    MMC_TGT_EXT = 4'h9,
    MMC_TGT_ICE = 4'hA
  } mmc_tgt_t;
  typedef enum logic [3:0] {
    MMC_ST_A = 4'b0001,
    MMC_ST_B = 4'b0010,
    MMC_ST_C = 4'b0100,
    MMC_ST_DONE = 4'b1000
  } mmc_state_t;
  // decode request from the cpu side
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic fetch;
    logic write;
    logic indirect;
  } mmc_req_t;
  // decoded answer and bus controls
  typedef struct packed {
    logic [3:0] target;
    logic ext;
    logic blocked;
    logic ale_mode;
    logic low_strobe;
    logic high_strobe;
    logic bus16;
    logic [2:0] wait_cap;
    logic wait_unlimited;
    logic auto_wait;
  } mmc_dec_t;
endpackage

// ===== verilog/mmc_top.sv
// memory map decoder and chip configuration loader
// assumes a nonvolatile byte port with one-cycle read latency and
// an axi4-lite master that keeps one read and one write open at most
`timescale 1ns/100ps
`default_nettype none
module mmc_top #(
  parameter bit LARGE = 1'b1 // one for the 24-bit variant
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic sys_rst, // async reset, active high
  input wire logic clk_en, // freezes all state when low
  input wire logic external_access_pin, // high: internal program memory
  input wire logic bus_width_pin, // high: 16-bit cycle when pin decides
  output logic [23:0] nv_addr, // config byte read address
  output logic nv_rd, // config byte read strobe
  input wire logic [7:0] nv_data, // config byte, one cycle after nv_rd
  input wire mmc_pkg::mmc_req_t req, // access to decode
  output mmc_pkg::mmc_dec_t dec, // registered decode result
  output logic cfg_ready, // config latched, bus may run
  output logic powerdown_allow, // powerdown permitted
  output logic watchdog_forced, // watchdog permanently on
  output logic wide_address_select, // 24-bit addressing
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import mmc_pkg::*;

  // ----------------------------------------------------------------
  // configuration load after reset
  // ----------------------------------------------------------------
  mmc_state_t st_r;
  logic rd_pend_r;
  logic [7:0] cfg_a_r, cfg_b_r, cfg_c_r;

  // each byte takes two cycles: strobe, then capture
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= MMC_ST_A;
      rd_pend_r <= 1'b0;
      cfg_a_r <= CFG_ERASED;
      cfg_b_r <= CFG_ERASED;
      cfg_c_r <= 8'h00;
    end else if (clk_en) begin
      rd_pend_r <= 1'b0;
      case (st_r)
        MMC_ST_A: begin
          if (!rd_pend_r) begin
            rd_pend_r <= 1'b1;
          end else begin
            cfg_a_r <= nv_data;
            st_r <= MMC_ST_B;
          end
        end
        MMC_ST_B: begin
          if (!rd_pend_r) begin
            rd_pend_r <= 1'b1;
          end else begin
            cfg_b_r <= nv_data;
            // small variant never reads a third byte
            if (nv_data[B_FETCH_C] && LARGE) begin
              st_r <= MMC_ST_C;
            end else begin
              st_r <= MMC_ST_DONE;
            end
          end
        end
        MMC_ST_C: begin
          if (!rd_pend_r) begin
            rd_pend_r <= 1'b1;
          end else begin
            cfg_c_r <= nv_data;
            st_r <= MMC_ST_DONE;
          end
        end
        MMC_ST_DONE: begin
          st_r <= MMC_ST_DONE;
        end
        default: begin
          st_r <= MMC_ST_A;
        end
      endcase
    end
  end

  always_comb begin
    nv_rd = 1'b0;
    nv_addr = CFG_A_ADDR;
    case (st_r)
      MMC_ST_A: begin
        nv_rd = !rd_pend_r;
        nv_addr = CFG_A_ADDR;
      end
      MMC_ST_B: begin
        nv_rd = !rd_pend_r;
        nv_addr = CFG_B_ADDR;
      end
      MMC_ST_C: begin
        nv_rd = !rd_pend_r;
        nv_addr = CFG_C_ADDR;
      end
      default: begin
        nv_rd = 1'b0;
        nv_addr = CFG_A_ADDR;
      end
    endcase
  end

  assign cfg_ready = (st_r == MMC_ST_DONE);
  assign powerdown_allow = cfg_a_r[A_POWERDOWN_ALLOW];
  assign watchdog_forced = !cfg_b_r[B_WATCHDOG_FORCE_BIT];
  assign wide_address_select = LARGE && cfg_c_r[C_WIDE];

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  logic mirror;
  logic ea_int;
  assign mirror = LARGE && cfg_c_r[C_MIRROR];
  assign ea_int = external_access_pin;

  function automatic mmc_tgt_t decode(input logic [23:0] a, input logic f,
                                      input logic mir, input logic ea);
    logic [15:0] lo;
    lo = a[15:0];
    decode = MMC_TGT_EXT;
    if (LARGE && a[23:16] == 8'hFF) begin
      if (lo >= 16'h2000) begin
        decode = ea ? MMC_TGT_PROG : MMC_TGT_EXT;
      end else if (lo >= 16'h0400 && lo <= 16'h05FF) begin
        decode = MMC_TGT_CODE_RAM;
      end else if (lo <= 16'h00FF) begin
        decode = MMC_TGT_ICE;
      end
    end else if (a[23:16] == 8'h00) begin
      if (f && lo <= 16'h03FF) begin
        decode = MMC_TGT_EXT;
      end else if (lo <= 16'h0017) begin
        decode = MMC_TGT_CPU_SFR;
      end else if (lo <= 16'h00FF) begin
        decode = MMC_TGT_LOW_REG;
      end else if (lo <= 16'h03FF) begin
        decode = LARGE ? MMC_TGT_EXT : MMC_TGT_UP_REG;
      end else if (in_rng(a, 24'h000400, LARGE ? 24'h0005FF : 24'h0004FF)) begin
        decode = MMC_TGT_CODE_RAM;
      end else if (LARGE && in_rng(a, 24'h001C00, 24'h001DFF)) begin
        decode = MMC_TGT_REG_RAM;
      end else if (in_rng(a, 24'h001E00, 24'h001EFF)) begin
        decode = MMC_TGT_CAN;
      end else if (in_rng(a, 24'h001F00, 24'h001FDF)) begin
        decode = MMC_TGT_PERIPH_SFR;
      end else if (in_rng(a, 24'h001FE0, 24'h001FFF)) begin
        decode = MMC_TGT_MM_SFR;
      end else if (lo >= 16'h2000) begin
        if (LARGE) begin
          decode = (mir && ea) ? MMC_TGT_PROG : MMC_TGT_EXT;
        end else if (lo <= 16'h9FFF) begin
          decode = (lo >= 16'h2080 || ea) ? MMC_TGT_PROG : MMC_TGT_EXT;
        end else begin
          decode = MMC_TGT_EXT;
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // bus controls from the latched configuration
  // ----------------------------------------------------------------
  mmc_tgt_t tgt;
  logic [2:0] ready_code;
  logic [1:0] width_code;
  logic rd_prot, wr_prot, blocked, ext, code_bad;
  logic [2:0] cap;
  logic bus16;
  assign tgt = decode(req.addr, req.fetch, mirror, ea_int);
  assign ext = (tgt == MMC_TGT_EXT);
  // code 01 locks writes only, code 10 locks data reads only
  assign rd_prot = !cfg_a_r[A_PROTECT_SEL_LO];
  assign wr_prot = !cfg_a_r[A_PROTECT_SEL_HI];
  // code ram refuses direct addressing
  assign code_bad = (tgt == MMC_TGT_CODE_RAM || tgt == MMC_TGT_UP_REG) && !req.indirect;
  assign blocked = code_bad || (tgt == MMC_TGT_PROG && ((req.write && wr_prot) ||
                   (!req.write && !req.fetch && rd_prot)));
  assign ready_code = {cfg_b_r[B_READY_LIMIT_B2], cfg_a_r[A_READY_LIMIT_B1],
                       cfg_a_r[A_READY_LIMIT_B0]};
  assign width_code = {cfg_b_r[B_BUS_SIZE_B1], cfg_a_r[A_BUS_SIZE_B0]};

  always_comb begin
    case (ready_code)
      3'h4: cap = 3'h1;
      3'h5: cap = 3'h2;
      3'h6: cap = 3'h3;
      default: cap = 3'h0;
    endcase
    case (width_code)
      2'h1: bus16 = 1'b1;
      2'h2: bus16 = 1'b0;
      2'h3: bus16 = bus_width_pin;
      default: bus16 = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec <= '0;
    end else if (clk_en) begin
      dec.target <= tgt;
      dec.ext <= req.valid && cfg_ready && ext && !blocked;
      dec.blocked <= req.valid && blocked;
      dec.ale_mode <= cfg_a_r[A_ALE];
      // strobe style: combined write, or split low and high writes
      dec.low_strobe <= req.valid && ext && req.write &&
                        (cfg_a_r[A_WR] || !req.addr[0]);
      dec.high_strobe <= req.valid && ext && (cfg_a_r[A_WR] ?
                         (bus16 && req.addr[0]) : (req.write && req.addr[0]));
      dec.bus16 <= bus16;
      dec.wait_cap <= cap;
      dec.wait_unlimited <= (ready_code == 3'h7);
      dec.auto_wait <= !cfg_b_r[B_MS0] && !cfg_b_r[B_MS1];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave: config readback, probe decoder, status
  // ----------------------------------------------------------------
  logic aw_got_r, w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [23:0] probe_r;
  logic [31:0] rdata_nxt;
  logic rd_ok;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (aw_got_r && w_got_r) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == REG_PROBE) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // probe address steers a second decoder instance for software checks
  logic [7:0] wstrb_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      probe_r <= '0;
      wstrb_r <= '0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wstrb_r <= {4'h0, s_axi_wstrb};
      end
      if (aw_got_r && w_got_r && awaddr_r == REG_PROBE) begin
        for (int i = 0; i < 3; i++) begin
          if (wstrb_r[i]) begin
            probe_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
          end
        end
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      REG_CFG_A: rdata_nxt = {24'h0, cfg_a_r};
      REG_CFG_B: rdata_nxt = {24'h0, cfg_b_r};
      REG_CFG_C: rdata_nxt = {24'h0, cfg_c_r};
      REG_STATUS: rdata_nxt = {28'h0, wide_address_select, watchdog_forced,
                               powerdown_allow, cfg_ready};
      REG_PROBE: rdata_nxt = {8'h0, probe_r};
      REG_RESULT: rdata_nxt = {28'h0, decode(probe_r, 1'b0, mirror, ea_int)};
      default: begin
        rdata_nxt = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/mmc_checker.sv
// concurrent checks on the decoder top ports
// assumes one clock domain; bound into mmc_top at the foot
`timescale 1ns/100ps
`default_nettype none
module mmc_checker #(
  parameter bit LARGE = 1'b1 // design variant
) (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic clk_en, // run enable
  input wire logic external_access_pin, // pin level
  input wire logic [23:0] nv_addr, // config address
  input wire logic nv_rd, // config read
  input wire mmc_pkg::mmc_req_t req, // request
  input wire mmc_pkg::mmc_dec_t dec, // decode result
  input wire logic cfg_ready, // loaded
  input wire logic powerdown_allow, // level
  input wire logic watchdog_forced, // level
  input wire logic wide_address_select, // level
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid // r valid
);
  import mmc_pkg::*;
  logic go;
  // a decode is judged only once the configuration governs it
  assign go = clk_en && cfg_ready && req.valid;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_fetch_low: assert property (
    $past(go && req.fetch && req.addr < 24'h000400) |-> dec.ext && dec.target == MMC_TGT_EXT)
    else $error("low fetch kept inside");
  chk_cpu_sfr: assert property (
    $past(go && !req.fetch && req.addr < 24'h000018) |-> dec.target == MMC_TGT_CPU_SFR)
    else $error("cpu sfr decode wrong");
  chk_low_file: assert property (
    $past(go && !req.fetch && req.addr inside {[24'h000018:24'h0000FF]})
    |-> dec.target == MMC_TGT_LOW_REG) else $error("lower file decode wrong");
  chk_can_area: assert property (
    $past(go && req.addr[23:8] == 16'h001E) |-> dec.target == MMC_TGT_CAN)
    else $error("can decode wrong");
  chk_mm_sfr: assert property (
    $past(go && req.addr[23:5] == 19'h000FF) |-> dec.target == MMC_TGT_MM_SFR)
    else $error("mapped sfr decode wrong");
  chk_top_prog: assert property (
    LARGE && $past(go && req.fetch && req.addr >= 24'hFF2080)
    |-> dec.target == ($past(external_access_pin) ? MMC_TGT_PROG : MMC_TGT_EXT))
    else $error("top program area wrong");
  chk_block_ext: assert property (
    dec.blocked |-> !dec.ext) else $error("blocked access went out");
  chk_cfg_frozen: assert property (
    cfg_ready && $past(cfg_ready) |-> $stable(powerdown_allow) && $stable(watchdog_forced)
    && $stable(wide_address_select)) else $error("config moved after load");
  chk_hold_ext: assert property (
    !cfg_ready |=> !dec.ext) else $error("bus cycle before config load");
  chk_no_reload: assert property (
    cfg_ready |-> !nv_rd) else $error("config read after load");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid) else $error("read not answered");
endmodule
bind mmc_top mmc_checker #(.LARGE(LARGE)) i_chk (.ref_clk, .sys_rst, .clk_en,
  .external_access_pin, .nv_addr, .nv_rd, .req, .dec, .cfg_ready, .powerdown_allow,
  .watchdog_forced, .wide_address_select, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// ===== tb/mmc_nv_model.sv
// nonvolatile configuration byte store beside the decoder
// assumes the one-cycle read latency of the loader port
`timescale 1ns/100ps
`default_nettype none
module mmc_nv_model (
  input wire logic ref_clk, // clock
  input wire logic [23:0] nv_addr, // byte address
  input wire logic nv_rd, // read strobe
  input wire logic [7:0] cfg_a, // first byte
  input wire logic [7:0] cfg_b, // second byte
  input wire logic [7:0] cfg_c, // third byte
  output logic [7:0] nv_data = 8'h5A // byte after a read
);
  import mmc_pkg::*;
  always @(posedge ref_clk) begin
    if (nv_rd) begin
      case (nv_addr)
        CFG_A_ADDR: nv_data <= cfg_a;
        CFG_B_ADDR: nv_data <= cfg_b;
        CFG_C_ADDR: nv_data <= cfg_c;
        default: nv_data <= CFG_ERASED;
      endcase
    end else begin
      // no hold time: a late sample must not see the old byte
      nv_data <= ~nv_data;
    end
  end
endmodule
`default_nettype wire

// ===== tb/memory_map_chip_config_test.sv
// self-checking bench for the memory map decoder, both variants
// assumes the byte store model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module memory_map_chip_config_test;
  import mmc_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, pin = 1'b1, bwp = 1'b0;
  logic [23:0] nv_addr, ad;
  logic nv_rd, cfg_ready, powerdown_allow, watchdog_forced, wide_address_select, f, w, i;
  logic [7:0] nv_data, ca = 8'hFF, cb = 8'hFF, cc = 8'hFF, ce;
  mmc_req_t req = '0;
  mmc_dec_t dec, hold, dec_s;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0, n_checks = 0;
  logic [2:0] rc [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [23:0] lo [12] = '{24'h000000, 24'h000018, 24'h000100, 24'h000400, 24'h000600,
    24'h001C00, 24'h001E00, 24'h001F00, 24'h001FE0, 24'h002000, 24'hFF0400, 24'hFF2080};
  logic [23:0] hi [12] = '{24'h000017, 24'h0000FF, 24'h0003FF, 24'h0005FF, 24'h001BFF,
    24'h001DFF, 24'h001EFF, 24'h001FDF, 24'h001FFF, 24'h00FFFF, 24'hFF05FF, 24'hFFFFFF};
  always #12.5 ref_clk = ~ref_clk;
  mmc_top #(.LARGE(1'b1)) i_dut (.ref_clk, .sys_rst, .clk_en, .external_access_pin(pin),
    .bus_width_pin(bwp), .nv_addr, .nv_rd, .nv_data, .req, .dec, .cfg_ready, .powerdown_allow,
    .watchdog_forced, .wide_address_select, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mmc_nv_model i_nv (.ref_clk, .nv_addr, .nv_rd, .nv_data, .cfg_a(ca), .cfg_b(cb), .cfg_c(cc));
  // small variant runs in lockstep: it reads the first two bytes at the same cycles
  mmc_top #(.LARGE(1'b0)) i_dut_s (.ref_clk, .sys_rst, .clk_en, .external_access_pin(pin),
    .bus_width_pin(bwp), .nv_addr(), .nv_rd(), .nv_data, .req, .dec(dec_s), .cfg_ready(),
    .powerdown_allow(), .watchdog_forced(), .wide_address_select(), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready);
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // bus tasks: ready is looked at mid-cycle, where it has settled
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rp;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rp = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        `CHK(rp, er)
        @(posedge ref_clk);
        return;
      end
    end
    n_errors++;
    stop_test();
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [33:0] got;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge ref_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        `CHK(got, {er, ed})
        @(posedge ref_clk);
        return;
      end
    end
    n_errors++;
    stop_test();
  endtask
  function automatic logic [23:0] rnd_addr;
    int r = $urandom % 12;
    case ($urandom % 3)
      0: return lo[r];
      1: return hi[r];
      default: return lo[r] + 24'($urandom % (hi[r] - lo[r] + 1));
    endcase
  endfunction
  function automatic logic [3:0] exp_tgt(input logic [23:0] a, input logic fe);
    if (fe && a < 24'h000400) return MMC_TGT_EXT;
    if (a < 24'h000018) return MMC_TGT_CPU_SFR;
    if (a < 24'h000100) return MMC_TGT_LOW_REG;
    if (a < 24'h000400) return MMC_TGT_EXT;
    if (a < 24'h000600 || a[23:9] == 15'h7F82) return MMC_TGT_CODE_RAM;
    if (a < 24'h001C00) return MMC_TGT_EXT;
    if (a < 24'h001E00) return MMC_TGT_REG_RAM;
    if (a < 24'h001F00) return MMC_TGT_CAN;
    if (a < 24'h001FE0) return MMC_TGT_PERIPH_SFR;
    if (a < 24'h002000) return MMC_TGT_MM_SFR;
    if (a < 24'h010000) return (pin && ce[2]) ? MMC_TGT_PROG : MMC_TGT_EXT;
    return pin ? MMC_TGT_PROG : MMC_TGT_EXT;
  endfunction
  function automatic logic [3:0] exp_tgt_s(input logic [23:0] a, input logic fe);
    if (a > 24'h00FFFF || (fe && a < 24'h000400)) return MMC_TGT_EXT;
    if (a < 24'h000018) return MMC_TGT_CPU_SFR;
    if (a < 24'h000100) return MMC_TGT_LOW_REG;
    if (a < 24'h000400) return MMC_TGT_UP_REG;
    if (a < 24'h000500) return MMC_TGT_CODE_RAM;
    if (a < 24'h001E00) return MMC_TGT_EXT;
    if (a < 24'h001F00) return MMC_TGT_CAN;
    if (a < 24'h001FE0) return MMC_TGT_PERIPH_SFR;
    if (a < 24'h002000) return MMC_TGT_MM_SFR;
    if (a < 24'h002080) return pin ? MMC_TGT_PROG : MMC_TGT_EXT;
    return (a < 24'h00A000) ? MMC_TGT_PROG : MMC_TGT_EXT;
  endfunction
  task automatic dec_one;
    logic [3:0] t;
    logic bl;
    logic [2:0] wc;
    @(posedge ref_clk);
    req <= '{1'b1, ad, f, w, i};
    pin <= 1'($urandom);
    bwp <= 1'($urandom);
    @(posedge ref_clk);
    @(negedge ref_clk);
    t = exp_tgt(ad, f);
    bl = (t == MMC_TGT_PROG && (w ? !ca[7] : !f && !ca[6])) || (t == MMC_TGT_CODE_RAM && !i);
    wc = {cb[1], ca[5:4]};
    `CHK(dec.target, t)
    `CHK(dec_s.target, exp_tgt_s(ad, f))
    `CHK(dec.blocked, bl)
    `CHK(dec.ext, t == MMC_TGT_EXT)
    `CHK(dec.ale_mode, ca[3])
    `CHK(dec.bus16, {cb[2], ca[1]} == 2'h1 || ({cb[2], ca[1]} == 2'h3 && bwp))
    `CHK(dec.wait_unlimited, wc == 3'h7)
    if (wc != 3'h7) `CHK(dec.wait_cap, wc[2] ? wc[1:0] + 3'h1 : 3'h0)
    if (cb[7] == cb[6]) `CHK(dec.auto_wait, !cb[7])
    if (w && t == MMC_TGT_EXT) `CHK(dec.low_strobe, ca[2] || !ad[0])
    if (w && !ca[2] && t == MMC_TGT_EXT) `CHK(dec.high_strobe, ad[0])
  endtask
  initial begin
    void'($urandom(32'h5325D0AE));
    for (int k = 0; k < 8; k++) begin
      ca = 8'($urandom);
      cb = 8'($urandom);
      cc = 8'($urandom);
      ca[7:6] = k[1:0];
      {cb[1], ca[5:4]} = rc[k % 5];
      cb[7:6] = {2{k[0]}};
      cb[5:4] = 2'h1;
      cb[0] = k != 2;
      cc[0] = 1'b0;
      cc[7:3] = 5'h1F;
      cc[2] = k[2];
      ce = cb[0] ? cc : 8'h00;
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int n = 0; n < 20 && cfg_ready !== 1'b1; n++) @(negedge ref_clk);
      `CHK(cfg_ready, 1'b1)
      if (cfg_ready !== 1'b1) stop_test();
      `CHK(powerdown_allow, ca[0])
      `CHK(watchdog_forced, !cb[3])
      `CHK(wide_address_select, ce[1])
      @(posedge ref_clk);
      axi_rd(REG_CFG_A, {24'h0, ca}, RESP_OKAY);
      axi_rd(REG_CFG_B, {24'h0, cb}, RESP_OKAY);
      axi_rd(REG_CFG_C, {24'h0, ce}, RESP_OKAY);
      axi_rd(REG_STATUS, {28'h0, ce[1], !cb[3], ca[0], 1'b1}, RESP_OKAY);
      if (k == 0) begin
        axi_rd(12'h0FC, 32'h0, RESP_SLVERR);
        axi_wr(REG_CFG_A, ~{24'h0, ca}, RESP_SLVERR);
        axi_rd(REG_CFG_A, {24'h0, ca}, RESP_OKAY);
      end
      ad = rnd_addr();
      axi_wr(REG_PROBE, {8'h00, ad}, RESP_OKAY);
      axi_rd(REG_PROBE, {8'h00, ad}, RESP_OKAY);
      axi_rd(REG_RESULT, {28'h0, exp_tgt(ad, 1'b0)}, RESP_OKAY);
      repeat (40) begin
        ad = rnd_addr();
        {f, w, i} = 3'($urandom);
        w = w && !f;
        i = i || f;
        dec_one();
      end
    end
    @(posedge ref_clk);
    clk_en <= 1'b0;
    req <= '{1'b1, 24'h001E00, 1'b0, 1'b0, 1'b1};
    @(negedge ref_clk);
    hold = dec;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(dec, hold)
    stop_test();
  end
endmodule
`default_nettype wire
